/* File: rtl/tmr_top.sv */
`include "tmr_regs.svh"

// -----------------------------------------------------------------------
// two-channel 8-bit timer / event counter with cascade
// -----------------------------------------------------------------------
module tmr_top (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire tmr_pkg::tmr_addr_t addr_i,
    input  wire tmr_pkg::tmr_byte_t wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output tmr_pkg::tmr_word_t     rdata_o,
    input  wire logic [1:0]        event_pin_i,
    input  wire logic              other_timer_interrupt_i,
    output logic [1:0]             timer_output_pin_o,
    output logic [1:0]             match_interrupt_o
);
    import tmr_pkg::*;

    // -------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------

    // exact match of a bus address
    function automatic logic addr_hit(input tmr_addr_t a,
                                      input tmr_addr_t t);
        addr_hit = (a == t);
    endfunction : addr_hit

    // prescaler tap: fires once per wrap of the masked bits
    function automatic logic div_tick(input tmr_byte_t pre,
                                      input tmr_byte_t mask);
        div_tick = ((pre & mask) == mask);
    endfunction : div_tick

    // count clock selection
    function automatic logic sel_tick(input tmr_clksel_t cs,
                                      input logic        ev_rise,
                                      input logic        ev_fall,
                                      input logic        other,
                                      input tmr_byte_t   pre);
        case (cs)
            TMR_CS_EV_FALL: sel_tick = ev_fall;
            TMR_CS_EV_RISE: sel_tick = ev_rise;
            TMR_CS_MAIN:    sel_tick = 1'b1;
            TMR_CS_DIV2:    sel_tick = div_tick(pre, `TMR_PRE_DIV2);
            TMR_CS_DIV4:    sel_tick = div_tick(pre, `TMR_PRE_DIV4);
            TMR_CS_DIV64:   sel_tick = div_tick(pre, `TMR_PRE_DIV64);
            TMR_CS_DIV256:  sel_tick = div_tick(pre, `TMR_PRE_DIV256);
            default:        sel_tick = other;
        endcase
    endfunction : sel_tick

    // -------------------------------------------------------------------
    // shared signals
    // -------------------------------------------------------------------
    tmr_byte_t  pre_r;
    tmr_word_t  rdata_r;
    logic       casc;
    logic       match16;
    logic       carry0;
    logic [1:0] ev_rise;
    logic [1:0] ev_fall;
    logic [1:0] wr_clk;
    logic [1:0] wr_mode;
    logic [1:0] wr_cmp;
    tmr_byte_t  cnt_w   [2];
    tmr_byte_t  cmp_w   [2];
    tmr_byte_t  mode_w  [2];
    tmr_byte_t  clk_w   [2];
    logic [1:0] tick_w;
    logic [1:0] ena_w;
    logic [1:0] clear_w;

    // -------------------------------------------------------------------
    // write strobes
    // -------------------------------------------------------------------
    assign wr_clk[0]  = wr_i && addr_hit(addr_i, `TMR_ADDR_CLKSEL0);
    assign wr_clk[1]  = wr_i && addr_hit(addr_i, `TMR_ADDR_CLKSEL1);
    assign wr_mode[0] = wr_i && addr_hit(addr_i, `TMR_ADDR_MODE0);
    assign wr_mode[1] = wr_i && addr_hit(addr_i, `TMR_ADDR_MODE1);
    assign wr_cmp[0]  = wr_i && addr_hit(addr_i, `TMR_ADDR_CMP0);
    assign wr_cmp[1]  = wr_i && addr_hit(addr_i, `TMR_ADDR_CMP1);

    // -------------------------------------------------------------------
    // cascade link between the two channels
    // -------------------------------------------------------------------
    assign casc    = mode_w[1][`TMR_BIT_CASC];
    assign match16 = ({cnt_w[1], cnt_w[0]} == {cmp_w[1], cmp_w[0]});
    assign carry0  = tick_w[0] && ena_w[0] && (cnt_w[0] == `TMR_CNT_MAX);

    // -------------------------------------------------------------------
    // main clock prescaler
    // -------------------------------------------------------------------

    // free-running divider feeding the division taps
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_r <= `TMR_CNT_RST;
        end else begin
            pre_r <= pre_r + 8'h01;
        end
    end

    // -------------------------------------------------------------------
    // external event inputs
    // -------------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_ev
        tmr_edge_sync u_sync (
            .clk_i  (clk_i),
            .rstn_i (rstn_i),
            .pin_i  (event_pin_i[p]),
            .rise_o (ev_rise[p]),
            .fall_o (ev_fall[p])
        );
    end

    // -------------------------------------------------------------------
    // per-channel counter, compare and output
    // -------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_ch
        tmr_byte_t clksel_r;
        tmr_byte_t mode_r;
        tmr_byte_t cmp_r;
        tmr_byte_t cmp_act_r;
        tmr_byte_t cnt_r;
        tmr_byte_t cnt_inc;
        tmr_byte_t cnt_nxt;
        tmr_byte_t mode_mask;
        logic      ff_r;
        logic      ff_nxt;
        logic      pwm_act_r;
        logic      pend_r;
        logic      late_r;
        logic      pin_r;
        logic      irq_r;
        logic      ena;
        logic      pwm;
        logic      inv;
        logic      oe;
        logic      own_tick;
        logic      tick;
        logic      own_hit;
        logic      clear_hit;
        logic      clr_cnt;
        logic      ovf;
        logic      pwm_match;
        logic      irq;
        logic      load_cmp;
        logic      set_req;
        logic      clr_req;
        logic      toggle;
        logic      lvl;

        // mode fields
        assign ena = mode_r[`TMR_BIT_ENA];
        assign pwm = mode_r[`TMR_BIT_PWM] && !casc;
        assign inv = mode_r[`TMR_BIT_INV];
        assign oe  = mode_r[`TMR_BIT_OE];
        assign mode_mask = (g == 0) ? `TMR_MODE_MASK0 : `TMR_MODE_MASK1;

        // count clock: upper channel follows lower carry in cascade
        assign own_tick = sel_tick(tmr_clksel_t'(clksel_r[2:0]),
                                   ev_rise[g], ev_fall[g],
                                   other_timer_interrupt_i, pre_r);
        assign tick = (g == 1 && casc) ? carry0 : own_tick;

        // compare against own value, or 16 bits for lower in cascade
        assign own_hit = (g == 0 && casc) ? match16
                                          : (cnt_r == cmp_r);
        assign clear_hit = (g == 1 && casc) ? clear_w[0]
                         : (tick && ena && own_hit && !pwm);

        // counter clear conditions and next value
        assign clr_cnt = !ena || (g == 1 && casc && !ena_w[0]);
        assign cnt_inc = cnt_r + 8'h01;
        assign cnt_nxt = clr_cnt   ? `TMR_CNT_RST :
                         clear_hit ? `TMR_CNT_RST :
                         tick      ? cnt_inc : cnt_r;

        // pwm overflow, equality and compare reload
        assign ovf       = tick && ena && (cnt_r == `TMR_CNT_MAX);
        assign pwm_match = pwm && tick && ena && (cnt_inc == cmp_act_r);
        assign load_cmp  = ovf && pend_r && !late_r;

        // match interrupt; upper stays quiet in cascade
        assign irq = (g == 1 && casc) ? 1'b0
                                      : (clear_hit || pwm_match);

        // output flop control from software and matches
        assign set_req = wr_mode[g] && !wdata_i[`TMR_BIT_PWM]
                      && wdata_i[`TMR_BIT_SET] && !wdata_i[`TMR_BIT_CLR];
        assign clr_req = wr_mode[g] && !wdata_i[`TMR_BIT_PWM]
                      && !wdata_i[`TMR_BIT_SET] && wdata_i[`TMR_BIT_CLR];
        assign toggle  = irq && !pwm && inv;
        assign ff_nxt  = set_req ? 1'b1 :
                         clr_req ? 1'b0 :
                         toggle  ? ~ff_r : ff_r;

        // pin level: pwm active level, else output flop
        assign lvl = pwm ? ((ena && pwm_act_r) ^ inv)
                         : ff_r;

        // exports to the shared logic
        assign cnt_w[g]   = cnt_r;
        assign cmp_w[g]   = cmp_r;
        assign mode_w[g]  = mode_r;
        assign clk_w[g]   = clksel_r;
        assign tick_w[g]  = tick;
        assign ena_w[g]   = ena;
        assign clear_w[g] = clear_hit;

        // software registers; set/clear bits are not stored
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                clksel_r <= `TMR_CLKSEL_RST;
                mode_r   <= `TMR_MODE_RST;
                cmp_r    <= `TMR_CMP_RST;
            end else begin
                if (wr_clk[g]) begin
                    clksel_r <= wdata_i & `TMR_CLKSEL_MASK;
                end
                if (wr_mode[g]) begin
                    mode_r <= wdata_i & mode_mask;
                end
                if (wr_cmp[g]) begin
                    cmp_r <= wdata_i;
                end
            end
        end

        // counter
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                cnt_r <= `TMR_CNT_RST;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end

        // pwm compare buffer; a write in the last step waits one more wrap
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                cmp_act_r <= `TMR_CMP_RST;
                pend_r    <= 1'b0;
                late_r    <= 1'b0;
            end else begin
                if (!pwm) begin
                    cmp_act_r <= cmp_r;
                end else if (load_cmp) begin
                    cmp_act_r <= cmp_r;
                end
                if (wr_cmp[g]) begin
                    pend_r <= 1'b1;
                    late_r <= (cnt_r == `TMR_CNT_MAX);
                end else if (ovf) begin
                    pend_r <= pend_r && late_r;
                    late_r <= 1'b0;
                end
            end
        end

        // pwm active phase
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                pwm_act_r <= 1'b0;
            end else if (!ena || !pwm) begin
                pwm_act_r <= 1'b0;
            end else if (ovf) begin
                pwm_act_r <= ((load_cmp ? cmp_r : cmp_act_r)
                              != 8'h00);
            end else if (pwm_match) begin
                pwm_act_r <= 1'b0;
            end
        end

        // output flop, pin and interrupt
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                ff_r  <= 1'b0;
                pin_r <= 1'b0;
                irq_r <= 1'b0;
            end else begin
                ff_r  <= ff_nxt;
                pin_r <= oe ? lvl : 1'b0;
                irq_r <= irq;
            end
        end

        assign timer_output_pin_o[g] = pin_r;
        assign match_interrupt_o[g]  = irq_r;
    end

    // -------------------------------------------------------------------
    // read data
    // -------------------------------------------------------------------
    tmr_word_t rd_nxt;
    tmr_word_t cnt_rd0;
    tmr_word_t cnt_rd1;

    // cascade returns the full 16-bit count at either count address
    assign cnt_rd0 = casc ? {cnt_w[1], cnt_w[0]}
                          : {8'h00, cnt_w[0]};
    assign cnt_rd1 = casc ? {cnt_w[1], cnt_w[0]}
                          : {8'h00, cnt_w[1]};

    // address selection, unmapped reads return zero
    always_comb begin
        if (addr_hit(addr_i, `TMR_ADDR_CLKSEL0)) begin
            rd_nxt = {8'h00, clk_w[0]};
        end else if (addr_hit(addr_i, `TMR_ADDR_CLKSEL1)) begin
            rd_nxt = {8'h00, clk_w[1]};
        end else if (addr_hit(addr_i, `TMR_ADDR_MODE0)) begin
            rd_nxt = {8'h00, mode_w[0]};
        end else if (addr_hit(addr_i, `TMR_ADDR_MODE1)) begin
            rd_nxt = {8'h00, mode_w[1]};
        end else if (addr_hit(addr_i, `TMR_ADDR_COUNT0)) begin
            rd_nxt = cnt_rd0;
        end else if (addr_hit(addr_i, `TMR_ADDR_COUNT1)) begin
            rd_nxt = cnt_rd1;
        end else if (addr_hit(addr_i, `TMR_ADDR_CMP0)) begin
            rd_nxt = {8'h00, cmp_w[0]};
        end else if (addr_hit(addr_i, `TMR_ADDR_CMP1)) begin
            rd_nxt = {8'h00, cmp_w[1]};
        end else begin
            rd_nxt = 16'h0000;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 16'h0000;
        end else if (rd_i) begin
            rdata_r <= rd_nxt;
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign rdata_o = rdata_r;

endmodule : tmr_top

/* File: shared/tmr_regs.svh */
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
// -----------------------------------------------------------------------
// two-channel 8-bit timer / event counter: constants
// -----------------------------------------------------------------------

// -----------------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------------
`define TMR_ADDR_CLKSEL0 32'hFFFFF5C4
`define TMR_ADDR_CLKSEL1 32'hFFFFF5C5
`define TMR_ADDR_MODE0   32'hFFFFF5C6
`define TMR_ADDR_MODE1   32'hFFFFF5C7
`define TMR_ADDR_COUNT0  32'hFFFFF5C8
`define TMR_ADDR_COUNT1  32'hFFFFF5C9
`define TMR_ADDR_CMP0    32'hFFFFF5CA
`define TMR_ADDR_CMP1    32'hFFFFF5CB

// -----------------------------------------------------------------------
// mode control fields
// -----------------------------------------------------------------------
`define TMR_BIT_ENA  7
`define TMR_BIT_PWM  6
`define TMR_BIT_CASC 4
`define TMR_BIT_SET  3
`define TMR_BIT_CLR  2
`define TMR_BIT_INV  1
`define TMR_BIT_OE   0

// -----------------------------------------------------------------------
// reset values, masks and prescaler taps
// -----------------------------------------------------------------------
`define TMR_CLKSEL_RST  8'h00
`define TMR_MODE_RST    8'h00
`define TMR_CMP_RST     8'h00
`define TMR_CNT_RST     8'h00
`define TMR_CLKSEL_MASK 8'h07
`define TMR_MODE_MASK0  8'hC3
`define TMR_MODE_MASK1  8'hD3
`define TMR_CNT_MAX     8'hFF
`define TMR_PRE_DIV2    8'h01
`define TMR_PRE_DIV4    8'h03
`define TMR_PRE_DIV64   8'h3F
`define TMR_PRE_DIV256  8'hFF

`endif

/* File: shared/tmr_pkg.sv */
// -----------------------------------------------------------------------
// types shared by the timer files
// -----------------------------------------------------------------------
package tmr_pkg;

    // count clock sources in clock select order
    typedef enum logic [2:0] {
        TMR_CS_EV_FALL,
        TMR_CS_EV_RISE,
        TMR_CS_MAIN,
        TMR_CS_DIV2,
        TMR_CS_DIV4,
        TMR_CS_DIV64,
        TMR_CS_DIV256,
        TMR_CS_OTHER
    } tmr_clksel_t;

    typedef logic [7:0]  tmr_byte_t;
    typedef logic [15:0] tmr_word_t;
    typedef logic [31:0] tmr_addr_t;

endpackage : tmr_pkg

/* File: rtl/tmr_edge_sync.sv */
// -----------------------------------------------------------------------
// event pin synchroniser and edge detector
// -----------------------------------------------------------------------
module tmr_edge_sync (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    import tmr_pkg::*;

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // two flops, then one more for the edge history
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // one pulse per settled edge
    assign rise_o = sync_r & ~prev_r;
    assign fall_o = ~sync_r & prev_r;

endmodule : tmr_edge_sync

/* File: dv/tmr_properties.sv */
`include "tmr_regs.svh"
// -----------------------------------------------------------------------
// port-level checks for the two-channel timer
// -----------------------------------------------------------------------
module tmr_properties (
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire tmr_pkg::tmr_addr_t addr_i,
    input  wire tmr_pkg::tmr_byte_t wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire tmr_pkg::tmr_word_t rdata_o,
    input  wire logic [1:0]         event_pin_i,
    input  wire logic               other_timer_interrupt_i,
    input  wire logic [1:0]         timer_output_pin_o,
    input  wire logic [1:0]         match_interrupt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // decoded bus accesses
    wire logic m0_wr = wr_i && addr_i == `TMR_ADDR_MODE0;
    wire logic cs_rd = rd_i && (addr_i == `TMR_ADDR_CLKSEL0
                                || addr_i == `TMR_ADDR_CLKSEL1);

    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    chk_clksel_read: assert property (cs_rd
        |=> rdata_o[15:3] == 13'h0000)
        else $error("clock select reads unused bits set");
    chk_mode0_read: assert property (rd_i
        && addr_i == `TMR_ADDR_MODE0
        |=> rdata_o[15:8] == 8'h00 && rdata_o[5:2] == 4'h0)
        else $error("mode ch0 reads fixed bits set");
    chk_mode1_read: assert property (rd_i
        && addr_i == `TMR_ADDR_MODE1
        |=> rdata_o[3:2] == 2'h0 && !rdata_o[5])
        else $error("mode ch1 set/clear bits not read as zero");
    chk_oe_low: assert property (m0_wr && !wdata_i[0]
        |=> ##1 !timer_output_pin_o[0])
        else $error("pin not low with output disabled");
    chk_flop_set: assert property (m0_wr && wdata_i[6:0] == 7'h09
        |=> ##1 timer_output_pin_o[0])
        else $error("flop set did not reach pin");
    chk_flop_clear: assert property (m0_wr && wdata_i[6:0] == 7'h05
        ##2 1'b1 |-> !timer_output_pin_o[0])
        else $error("flop clear did not reach pin");
    chk_pwm_idle: assert property (m0_wr && wdata_i[7:6] == 2'b01
        && wdata_i[0] |=> ##1 timer_output_pin_o[0] == $past(wdata_i[1], 2))
        else $error("stopped pwm output not inactive");
    chk_cmp_readback: assert property (wr_i
        && addr_i == `TMR_ADDR_CMP0
        ##2 rd_i && addr_i == `TMR_ADDR_CMP0
        |=> rdata_o == {8'h00, $past(wdata_i, 3)})
        else $error("compare value not read back");

    // main scenarios reached
    cover property (match_interrupt_o[0]);
    cover property ($rose(timer_output_pin_o[0]));
    cover property (match_interrupt_o[1]);
endmodule : tmr_properties

bind tmr_top tmr_properties u_tmr_properties (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_pin_i(event_pin_i),
    .other_timer_interrupt_i(other_timer_interrupt_i),
    .timer_output_pin_o(timer_output_pin_o),
    .match_interrupt_o(match_interrupt_o));

/* File: dv/tmr_far_model.sv */
// -----------------------------------------------------------------------
// event pins and neighbouring timer interrupt source
// -----------------------------------------------------------------------
module tmr_far_model (
    input  wire logic       clk_i,
    output logic      [1:0] event_pin_o,
    output logic            other_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins idle low so no stray edge at start
    initial begin
        event_pin_o = 2'h0;
        other_irq_o = 1'b0;
    end

    // wide pulses, well above the two-flop synchroniser
    task send_edges(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_i);
            event_pin_o[ch] <= 1'b1;
            repeat (4) @(posedge clk_i);
            event_pin_o[ch] <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : send_edges

    // one-cycle interrupt pulses from the other timer
    task send_ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            other_irq_o <= 1'b1;
            @(posedge clk_i);
            other_irq_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : send_ticks
endmodule : tmr_far_model

/* File: dv/tmr_top_bench.sv */
`include "tmr_regs.svh"
// -----------------------------------------------------------------------
// self-checking bench for the two-channel timer
// -----------------------------------------------------------------------
module tmr_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;

    logic      clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    tmr_addr_t addr_i = '0;
    tmr_byte_t wdata_i = '0;
    tmr_word_t rdata_o;
    logic      [1:0] ev, pin, irq;
    logic      oti;
    int        errors = 0, total_checks = 0, seed = 16280;
    int        irq_cnt[2] = '{0, 0};
    int        divs[5] = '{1, 2, 4, 64, 256};
    tmr_byte_t msk[8] = '{8'h07, 8'h07, 8'hC3, 8'hD3,
                          8'h00, 8'h00, 8'hFF, 8'hFF};

    // clock and interrupt tally
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        for (int c = 0; c < 2; c++) if (irq[c] === 1'b1) irq_cnt[c]++;

    tmr_top u_tmr_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .event_pin_i(ev), .other_timer_interrupt_i(oti),
        .timer_output_pin_o(pin), .match_interrupt_o(irq));
    tmr_far_model u_tmr_far_model (.clk_i(clk_i), .event_pin_o(ev),
        .other_irq_o(oti));

    // -------------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input tmr_addr_t a, input tmr_byte_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input tmr_addr_t a, input tmr_word_t e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask : rd

    task wait_irq(input int ch);
        repeat (3000) begin
            @(posedge clk_i);
            #1;
            if (irq[ch] === 1'b1) return;
        end
        errors++;
        $display("Error %0t: no match interrupt", $time);
        stop_test();
    endtask : wait_irq

    // interval between two matches, and the flop toggling at each
    task period(input int ch, input int n);
        realtime t0;
        logic    p0;
        wait_irq(ch);
        t0 = $realtime;
        p0 = pin[ch];
        wait_irq(ch);
        chk(int'(($realtime - t0) / 100.0), n);
        chk(pin[ch] ^ p0, 1);
    endtask : period

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        tmr_byte_t d;
        tmr_byte_t regm[8];
        int        hi;
        logic [2:0] evsel[3] = '{3'd1, 3'd0, 3'd7};
        tmr_byte_t pm[3] = '{8'hC1, 8'hC3, 8'hC3};
        tmr_byte_t sc[4] = '{8'h09, 8'h05, 8'h08, 8'h01};
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        // reset values and an unmapped place
        for (int i = 0; i < 8; i++)
            rd(`TMR_ADDR_CLKSEL0 + i, 16'h0000);
        rd(32'hFFFFF5CC, 16'h0000);
        // random write and read back, timer kept stopped
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            if (d[3]) d[2] = 1'b0;
            d[7] = 1'b0;
            regm[i] = d & msk[i];
            wr(`TMR_ADDR_CLKSEL0 + i, d);
            rd(`TMR_ADDR_CLKSEL0 + i, {8'h00, regm[i]});
        end
        wr(`TMR_ADDR_MODE1, 8'h00);
        // interval timer over every internal clock division
        wr(`TMR_ADDR_CMP0, 8'h03);
        for (int s = 2; s < 7; s++) begin
            wr(`TMR_ADDR_MODE0, 8'h00);
            wr(`TMR_ADDR_CLKSEL0, s[7:0]);
            wr(`TMR_ADDR_MODE0, 8'h83);
            period(0, 4 * divs[s - 2]);
        end
        // external edges and the other timer as count clock
        foreach (evsel[k]) begin
            wr(`TMR_ADDR_MODE0, 8'h00);
            wr(`TMR_ADDR_CLKSEL0, {5'h00, evsel[k]});
            wr(`TMR_ADDR_CMP0, 8'h02);
            wr(`TMR_ADDR_MODE0, 8'h80);
            irq_cnt[0] = 0;
            if (evsel[k] == 3'd7) u_tmr_far_model.send_ticks(9);
            else u_tmr_far_model.send_edges(0, 9);
            repeat (10) @(posedge clk_i);
            chk(irq_cnt[0], 3);
        end
        // upper channel on its own, then stopped reads zero
        wr(`TMR_ADDR_MODE0, 8'h00);
        wr(`TMR_ADDR_CMP1, 8'h05);
        wr(`TMR_ADDR_CLKSEL1, 8'h02);
        wr(`TMR_ADDR_MODE1, 8'h83);
        period(1, 6);
        wr(`TMR_ADDR_MODE1, 8'h00);
        rd(`TMR_ADDR_COUNT1, 16'h0000);
        // cascade: upper clock select is ignored
        wr(`TMR_ADDR_CMP0, 8'h02);
        wr(`TMR_ADDR_CMP1, 8'h01);
        wr(`TMR_ADDR_CLKSEL0, 8'h02);
        wr(`TMR_ADDR_CLKSEL1, 8'h06);
        wr(`TMR_ADDR_MODE1, 8'h10);
        wr(`TMR_ADDR_MODE1, 8'h90);
        irq_cnt[1] = 0;
        wr(`TMR_ADDR_MODE0, 8'h83);
        period(0, 259);
        chk(irq_cnt[1], 0);
        wr(`TMR_ADDR_MODE0, 8'h00);
        rd(`TMR_ADDR_COUNT0, 16'h0000);
        wr(`TMR_ADDR_MODE1, 8'h00);
        // pwm duty for both active levels
        wr(`TMR_ADDR_CMP0, 8'h40);
        wr(`TMR_ADDR_MODE0, 8'h40);
        wr(`TMR_ADDR_MODE0, 8'h41);
        foreach (pm[k]) begin
            if (k == 2) wr(`TMR_ADDR_CMP0, 8'h80);
            wr(`TMR_ADDR_MODE0, pm[k]);
            repeat (300) @(posedge clk_i);
            hi = 0;
            repeat (256) begin
                @(posedge clk_i);
                #1;
                if ((pin[0] ^ pm[k][1]) === 1'b1) hi++;
            end
            if (k < 2) chk(hi, 32'h40);
            else chk(hi, 32'h80);
        end
        wr(`TMR_ADDR_MODE0, 8'h43);
        @(posedge clk_i);
        #1;
        chk(pin[0], 1);
        // flop set with output enabled and disabled, flop clear with output enabled
        foreach (sc[k]) begin
            wr(`TMR_ADDR_MODE0, sc[k]);
            @(posedge clk_i);
            #1;
            chk(pin[0], (k == 0 || k == 3) ? 1 : 0);
        end
        stop_test();
    end
endmodule : tmr_top_bench
